// [rtl/alt_reg_map.v]
`timescale 1ns/1ps
`include "alt_map.vh"
module alt_reg_map #(
  parameter [6:0] P_DEV_ADDR = `ALT_BUS_ADDR,
  parameter [7:0] P_IDENTITY = `ALT_IDENTITY_VAL
) (
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  input  wire        i_scl,
  input  wire        i_sda,
  output wire        o_sda,
  output wire        o_sda_oe_n,
  input  wire        i_active,
  input  wire        i_sample_valid,
  input  wire [19:0] i_pres_sample,
  input  wire [11:0] i_temp_sample,
  input  wire [7:0]  i_fifo_flags,
  input  wire [7:0]  i_fifo_byte,
  input  wire [7:0]  i_overflow_time,
  input  wire [7:0]  i_int_cause,
  output wire        o_fifo_pop,
  output wire [7:0]  o_fifo_config,
  output wire [7:0]  o_data_event_config,
  output wire [15:0] o_sea_level_ref
);

localparam [6:0] S_IDLE = 7'h01;
localparam [6:0] S_ADDR = 7'h02;
localparam [6:0] S_AACK = 7'h04;
localparam [6:0] S_RX   = 7'h08;
localparam [6:0] S_WACK = 7'h10;
localparam [6:0] S_TX   = 7'h20;
localparam [6:0] S_MACK = 7'h40;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and bus conditions

reg        scl_m;
reg        scl_s;
reg        scl_d;
reg        sda_m;
reg        sda_s;
reg        sda_d;

always @(posedge i_sys_clk)
begin
  if (!i_rst_n)
  begin
    scl_m <= 1'b1;
    scl_s <= 1'b1;
    scl_d <= 1'b1;
    sda_m <= 1'b1;
    sda_s <= 1'b1;
    sda_d <= 1'b1;
  end
  else
  begin
    scl_m <= i_scl;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= i_sda;
    sda_s <= sda_m;
    sda_d <= sda_s;
  end
end

wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

////////////////////////////////////////////////////////////////////////////////
// register storage declarations

reg  [19:0] pres_out;
reg  [11:0] temp_out;
reg  [19:0] pres_chg;
reg  [11:0] temp_chg;
reg  [7:0]  dr_flags;
reg  [7:0]  fifo_flags;
reg  [7:0]  ovf_time;
reg  [7:0]  sys_state;
reg  [7:0]  int_cause;
reg  [7:0]  fifo_cfg;
reg  [7:0]  event_cfg;
reg  [7:0]  ref_high;
reg  [7:0]  ref_low;
reg         active_d;

wire fifo_on = |fifo_cfg[`ALT_FMODE_HI:`ALT_FMODE_LO];

// burst pointer successor
function [7:0] next_ptr;
  input [7:0] ptr_in;
  input       fifo_en;
  begin
    case (ptr_in)
      `ALT_T_OUT_LOW:  next_ptr = `ALT_STATUS_ALIAS;
      `ALT_T_CHG_LOW:  next_ptr = `ALT_DR_FLAGS;
      `ALT_P_OUT_HIGH: next_ptr = fifo_en ? `ALT_P_OUT_HIGH : `ALT_P_OUT_MID;
      `ALT_FIFO_PORT:  next_ptr = `ALT_FIFO_PORT;
      default:         next_ptr = ptr_in + 8'h01;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// read data selection

reg  [7:0] ptr;
reg  [7:0] rd_data;

always @*
begin
  case (ptr)
    `ALT_STATUS_ALIAS: rd_data = fifo_on ? fifo_flags : dr_flags;
    `ALT_P_OUT_HIGH:   rd_data = fifo_on ? i_fifo_byte : pres_out[19:12];
    `ALT_P_OUT_MID:    rd_data = pres_out[11:4];
    `ALT_P_OUT_LOW:    rd_data = {pres_out[3:0], 4'h0};
    `ALT_T_OUT_HIGH:   rd_data = temp_out[11:4];
    `ALT_T_OUT_LOW:    rd_data = {temp_out[3:0], 4'h0};
    `ALT_DR_FLAGS:     rd_data = dr_flags;
    `ALT_P_CHG_HIGH:   rd_data = pres_chg[19:12];
    `ALT_P_CHG_MID:    rd_data = pres_chg[11:4];
    `ALT_P_CHG_LOW:    rd_data = {pres_chg[3:0], 4'h0};
    `ALT_T_CHG_HIGH:   rd_data = temp_chg[11:4];
    `ALT_T_CHG_LOW:    rd_data = {temp_chg[3:0], 4'h0};
    `ALT_IDENTITY:     rd_data = P_IDENTITY;
    `ALT_FIFO_FLAGS:   rd_data = fifo_flags;
    `ALT_FIFO_PORT:    rd_data = i_fifo_byte;
    `ALT_FIFO_CONFIG:  rd_data = fifo_cfg;
    `ALT_OVF_TIME:     rd_data = ovf_time;
    `ALT_SYS_STATE:    rd_data = sys_state;
    `ALT_INT_CAUSE:    rd_data = int_cause;
    `ALT_EVENT_CONFIG: rd_data = event_cfg;
    `ALT_REF_HIGH:     rd_data = ref_high;
    `ALT_REF_LOW:      rd_data = ref_low;
    default:           rd_data = `ALT_ZERO_RST;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// serial slave state machine

reg  [6:0] state;
reg  [3:0] bit_cnt;
reg  [7:0] shift;
reg  [7:0] tx;
reg        rw;
reg        first;
reg        drive_low;

wire byte_done = scl_fall & (bit_cnt == `ALT_BYTE_BITS);
wire do_load   = scl_fall & (((state == S_AACK) & rw) | (state == S_MACK));
wire do_write  = byte_done & (state == S_RX) & ~first;

always @(posedge i_sys_clk)
begin
  if (!i_rst_n)
  begin
    state     <= S_IDLE;
    bit_cnt   <= 4'h0;
    shift     <= 8'h00;
    tx        <= 8'h00;
    rw        <= 1'b0;
    first     <= 1'b0;
    drive_low <= 1'b0;
    ptr       <= `ALT_STATUS_ALIAS;
  end
  else if (stop_c)
  begin
    state     <= S_IDLE;
    drive_low <= 1'b0;
  end
  else if (start_c)
  begin
    state     <= S_ADDR;
    bit_cnt   <= 4'h0;
    drive_low <= 1'b0;
  end
  else
  begin
    case (state)
      S_IDLE:
      begin
        drive_low <= 1'b0;
      end
      S_ADDR, S_RX:
      begin
        if (scl_rise)
        begin
          shift   <= {shift[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
        else if (byte_done)
        begin
          bit_cnt <= 4'h0;
          if (state == S_ADDR)
          begin
            if (shift[7:1] == P_DEV_ADDR)
            begin
              state     <= S_AACK;
              rw        <= shift[0];
              drive_low <= 1'b1;
            end
            else
              state <= S_IDLE;
          end
          else
          begin
            state     <= S_WACK;
            drive_low <= 1'b1;
            first     <= 1'b0;
            // address byte then advance after writes
            if (first)
              ptr <= shift;
            else
              ptr <= next_ptr(ptr, fifo_on);
          end
        end
      end
      S_AACK, S_MACK:
      begin
        if (scl_rise & (state == S_MACK) & sda_s)
          state <= S_IDLE;
        else if (do_load)
        begin
          state     <= S_TX;
          tx        <= rd_data;
          drive_low <= ~rd_data[7];
          bit_cnt   <= 4'h0;
          ptr       <= next_ptr(ptr, fifo_on);
        end
        else if (scl_fall)
        begin
          state     <= S_RX;
          first     <= 1'b1;
          drive_low <= 1'b0;
          bit_cnt   <= 4'h0;
        end
      end
      S_WACK:
      begin
        if (scl_fall)
        begin
          state     <= S_RX;
          drive_low <= 1'b0;
        end
      end
      S_TX:
      begin
        if (scl_rise)
          bit_cnt <= bit_cnt + 4'h1;
        else if (byte_done)
        begin
          state     <= S_MACK;
          drive_low <= 1'b0;
        end
        else if (scl_fall)
        begin
          drive_low <= ~tx[6];
          tx        <= {tx[6:0], 1'b0};
        end
      end
      default:
      begin
        state     <= S_IDLE;
        drive_low <= 1'b0;
      end
    endcase
  end
end

assign o_sda      = 1'b0;
assign o_sda_oe_n = ~drive_low;
// fifo drain on port or root read
assign o_fifo_pop = do_load & ((ptr == `ALT_FIFO_PORT) | ((ptr == `ALT_P_OUT_HIGH) & fifo_on));

////////////////////////////////////////////////////////////////////////////////
// volatile data registers

wire go_active = i_active & ~active_d;
wire rd_pres   = do_load & ~fifo_on & (ptr == `ALT_P_OUT_HIGH);
wire rd_temp   = do_load & (ptr == `ALT_T_OUT_HIGH);

always @(posedge i_sys_clk)
begin
  if (!i_rst_n)
  begin
    active_d   <= 1'b0;
    pres_out   <= 20'h00000;
    temp_out   <= 12'h000;
    pres_chg   <= 20'h00000;
    temp_chg   <= 12'h000;
    dr_flags   <= `ALT_ZERO_RST;
    fifo_flags <= `ALT_ZERO_RST;
    ovf_time   <= `ALT_ZERO_RST;
    sys_state  <= `ALT_ZERO_RST;
    int_cause  <= `ALT_ZERO_RST;
  end
  else
  begin
    active_d  <= i_active;
    int_cause <= i_int_cause;
    // clear volatile set except int_cause on going active
    if (go_active)
    begin
      pres_out   <= 20'h00000;
      temp_out   <= 12'h000;
      pres_chg   <= 20'h00000;
      temp_chg   <= 12'h000;
      dr_flags   <= `ALT_ZERO_RST;
      fifo_flags <= `ALT_ZERO_RST;
      ovf_time   <= `ALT_ZERO_RST;
      sys_state  <= `ALT_ZERO_RST;
    end
    else
    begin
      fifo_flags <= i_fifo_flags;
      ovf_time   <= i_overflow_time;
      sys_state  <= {7'h00, i_active};
      if (i_sample_valid)
      begin
        pres_chg <= i_pres_sample - pres_out;
        temp_chg <= i_temp_sample - temp_out;
        pres_out <= i_pres_sample;
        temp_out <= i_temp_sample;
        // new sample sets, overwrite if unread; set wins over clear
        dr_flags[`ALT_PTOW_BIT] <= dr_flags[`ALT_PTDR_BIT] | dr_flags[`ALT_PTOW_BIT];
        dr_flags[`ALT_POW_BIT]  <= dr_flags[`ALT_PDR_BIT] | dr_flags[`ALT_POW_BIT];
        dr_flags[`ALT_TOW_BIT]  <= dr_flags[`ALT_TDR_BIT] | dr_flags[`ALT_TOW_BIT];
        dr_flags[`ALT_PTDR_BIT] <= 1'b1;
        dr_flags[`ALT_PDR_BIT]  <= 1'b1;
        dr_flags[`ALT_TDR_BIT]  <= 1'b1;
      end
      else
      begin
        if (rd_pres)
        begin
          dr_flags[`ALT_PDR_BIT]  <= 1'b0;
          dr_flags[`ALT_POW_BIT]  <= 1'b0;
          dr_flags[`ALT_PTDR_BIT] <= 1'b0;
          dr_flags[`ALT_PTOW_BIT] <= 1'b0;
        end
        if (rd_temp)
        begin
          dr_flags[`ALT_TDR_BIT]  <= 1'b0;
          dr_flags[`ALT_TOW_BIT]  <= 1'b0;
          dr_flags[`ALT_PTDR_BIT] <= 1'b0;
          dr_flags[`ALT_PTOW_BIT] <= 1'b0;
        end
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// retained writable registers

always @(posedge i_sys_clk)
begin
  if (!i_rst_n)
  begin
    fifo_cfg  <= `ALT_ZERO_RST;
    event_cfg <= `ALT_ZERO_RST;
    ref_high  <= `ALT_REF_HIGH_RST;
    ref_low   <= `ALT_REF_LOW_RST;
  end
  // writes in any mode, untouched by mode change
  else if (do_write)
  begin
    case (ptr)
      `ALT_FIFO_CONFIG:  fifo_cfg  <= shift;
      `ALT_EVENT_CONFIG: event_cfg <= shift;
      `ALT_REF_HIGH:     ref_high  <= shift;
      `ALT_REF_LOW:      ref_low   <= shift;
      default:           fifo_cfg  <= fifo_cfg;
    endcase
  end
end

assign o_fifo_config       = fifo_cfg;
assign o_data_event_config = event_cfg;
assign o_sea_level_ref     = {ref_high, ref_low};

endmodule // alt_reg_map

// [rtl/alt_map.vh]
`ifndef ALT_MAP_VH
`define ALT_MAP_VH
// register offsets
`define ALT_STATUS_ALIAS  8'h00
`define ALT_P_OUT_HIGH    8'h01
`define ALT_P_OUT_MID     8'h02
`define ALT_P_OUT_LOW     8'h03
`define ALT_T_OUT_HIGH    8'h04
`define ALT_T_OUT_LOW     8'h05
`define ALT_DR_FLAGS      8'h06
`define ALT_P_CHG_HIGH    8'h07
`define ALT_P_CHG_MID     8'h08
`define ALT_P_CHG_LOW     8'h09
`define ALT_T_CHG_HIGH    8'h0a
`define ALT_T_CHG_LOW     8'h0b
`define ALT_IDENTITY      8'h0c
`define ALT_FIFO_FLAGS    8'h0d
`define ALT_FIFO_PORT     8'h0e
`define ALT_FIFO_CONFIG   8'h0f
`define ALT_OVF_TIME      8'h10
`define ALT_SYS_STATE     8'h11
`define ALT_INT_CAUSE     8'h12
`define ALT_EVENT_CONFIG  8'h13
`define ALT_REF_HIGH      8'h14
`define ALT_REF_LOW       8'h15
// reset values
`define ALT_ZERO_RST      8'h00
`define ALT_REF_HIGH_RST  8'hc5
`define ALT_REF_LOW_RST   8'he7
// identity value is arbitrary
`define ALT_IDENTITY_VAL  8'h5a
// bus address
`define ALT_BUS_ADDR      7'h60
// fifo operation select field
`define ALT_FMODE_HI      7
`define ALT_FMODE_LO      6
// data ready flag bits
`define ALT_TDR_BIT       1
`define ALT_PDR_BIT       2
`define ALT_PTDR_BIT      3
`define ALT_TOW_BIT       5
`define ALT_POW_BIT       6
`define ALT_PTOW_BIT      7
// bits per byte on the bus
`define ALT_BYTE_BITS     4'h8
`endif

// [tb/alt_reg_map_asserts.sv]
`timescale 1ns/1ps
module alt_reg_map_asserts (
  input wire        i_sys_clk,
  input wire        i_rst_n,
  input wire        i_scl,
  input wire        i_active,
  input wire        o_sda,
  input wire        o_sda_oe_n,
  input wire        o_fifo_pop,
  input wire [7:0]  o_fifo_config,
  input wire [7:0]  o_data_event_config,
  input wire [15:0] o_sea_level_ref
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  chk_oe_reset: assert property (!i_rst_n |=> o_sda_oe_n && !o_fifo_pop)
    else $error("bus driven after reset");
  chk_ref_reset: assert property (!i_rst_n |=> o_sea_level_ref == 16'hc5e7)
    else $error("reference reset value wrong");
  chk_cfg_reset: assert property (!i_rst_n |=>
    o_fifo_config == 8'h00 && o_data_event_config == 8'h00)
    else $error("config reset value wrong");
  chk_sda_zero: assert property (disable iff (!i_rst_n) o_sda == 1'b0)
    else $error("data pin driven high");
  chk_oe_scl_low: assert property (disable iff (!i_rst_n)
    $changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl))
    else $error("data changed while clock high");
  chk_pop_scl_low: assert property (disable iff (!i_rst_n)
    o_fifo_pop |-> !i_scl && !$past(i_scl))
    else $error("fifo pop outside clock low");
  chk_pop_pulse: assert property (disable iff (!i_rst_n) o_fifo_pop |=> !o_fifo_pop)
    else $error("fifo pop longer than one cycle");
  chk_active_keep: assert property (disable iff (!i_rst_n)
    $rose(i_active) |=> $stable(o_sea_level_ref) && $stable(o_fifo_config))
    else $error("retained register changed");
  cover property (disable iff (!i_rst_n) o_fifo_pop);
  cover property (disable iff (!i_rst_n) $rose(i_active));
  cover property (disable iff (!i_rst_n) $fell(o_sda_oe_n));
endmodule // alt_reg_map_asserts
bind alt_reg_map alt_reg_map_asserts alt_reg_map_asserts_i (
  .i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n),
  .i_scl(i_scl),
  .i_active(i_active),
  .o_sda(o_sda),
  .o_sda_oe_n(o_sda_oe_n),
  .o_fifo_pop(o_fifo_pop),
  .o_fifo_config(o_fifo_config),
  .o_data_event_config(o_data_event_config),
  .o_sea_level_ref(o_sea_level_ref)
);

// [tb/alt_i2c_host.sv]
`timescale 1ns/1ps
module alt_i2c_host (
  input  wire i_sys_clk,
  input  wire i_sda,
  output reg  o_scl,
  output reg  o_sda
);
  localparam Q = 8;
  initial o_scl = 1'b1;
  initial o_sda = 1'b1;
  // one bus phase, above the minimum half period
  task ph(input c, input d);
    begin
      o_scl <= c;
      o_sda <= d;
      repeat (Q) @(posedge i_sys_clk);
    end
  endtask
  task start;
    begin
      ph(o_scl, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
      ph(1'b0, 1'b0);
    end
  endtask
  task stop;
    begin
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
    end
  endtask
  // data set in clock low, sampled at end of clock high
  task bit_io(input b, output r);
    begin
      ph(1'b0, b);
      ph(1'b1, b);
      r = i_sda;
      ph(1'b0, b);
    end
  endtask
  task xfer(input [7:0] d, input ack_in, output [7:0] q, output ack);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bit_io(d[k], q[k]);
      bit_io(ack_in, ack);
    end
  endtask
endmodule // alt_i2c_host

// [tb/alt_reg_map_tb.sv]
`timescale 1ns/1ps
`include "alt_map.vh"
module alt_reg_map_tb;
  reg         i_sys_clk = 1'b0;
  reg         i_rst_n = 1'b0;
  reg         i_active = 1'b0;
  reg         i_sample_valid = 1'b0;
  reg  [19:0] i_pres_sample = 20'h00000;
  reg  [11:0] i_temp_sample = 12'h000;
  wire        scl;
  wire        m_sda;
  wire        sda;
  wire        o_sda;
  wire        o_sda_oe_n;
  wire        o_fifo_pop;
  wire [7:0]  o_fifo_config;
  wire [7:0]  o_data_event_config;
  wire [15:0] o_sea_level_ref;
  integer     err_count = 0;
  integer     samples_checked = 0;
  integer     pops = 0;
  integer     p0;
  integer     r;
  reg  [55:0] rows [0:4];
  reg  [7:0]  q;
  reg         ak;
  always #12.5 i_sys_clk = ~i_sys_clk;
  // open-drain data line with pull-up
  assign sda = m_sda & (o_sda_oe_n | o_sda);
  always @(posedge i_sys_clk)
    if (o_fifo_pop === 1'b1)
      pops <= pops + 1;
  alt_i2c_host alt_i2c_host_i (
    .i_sys_clk(i_sys_clk),
    .i_sda(sda),
    .o_scl(scl),
    .o_sda(m_sda)
  );
  alt_reg_map alt_reg_map_i (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_scl(scl),
    .i_sda(sda),
    .o_sda(o_sda),
    .o_sda_oe_n(o_sda_oe_n),
    .i_active(i_active),
    .i_sample_valid(i_sample_valid),
    .i_pres_sample(i_pres_sample),
    .i_temp_sample(i_temp_sample),
    .i_fifo_flags(8'h3c),
    .i_fifo_byte(8'h77),
    .i_overflow_time(8'h21),
    .i_int_cause(8'h42),
    .o_fifo_pop(o_fifo_pop),
    .o_fifo_config(o_fifo_config),
    .o_data_event_config(o_data_event_config),
    .o_sea_level_ref(o_sea_level_ref)
  );
  task chk(input string n, input [47:0] s, input [47:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e)
      begin
        err_count = err_count + 1;
        $display("wrong value %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task pt(input [7:0] a);
    begin
      alt_i2c_host_i.start;
      alt_i2c_host_i.xfer({`ALT_BUS_ADDR, 1'b0}, 1'b1, q, ak);
      chk("addr ack", ak, 0);
      alt_i2c_host_i.xfer(a, 1'b1, q, ak);
      chk("ptr ack", ak, 0);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      pt(a);
      alt_i2c_host_i.xfer(d, 1'b1, q, ak);
      alt_i2c_host_i.stop;
    end
  endtask
  task rd_chk(input [7:0] a, input [47:0] e);
    integer k;
    begin
      pt(a);
      alt_i2c_host_i.start;
      alt_i2c_host_i.xfer({`ALT_BUS_ADDR, 1'b1}, 1'b1, q, ak);
      for (k = 0; k < 6; k = k + 1)
      begin
        alt_i2c_host_i.xfer(8'hff, k == 5, q, ak);
        chk("read byte", q, e[47 - 8 * k -: 8]);
      end
      alt_i2c_host_i.stop;
    end
  endtask
  task smp(input [19:0] p, input [11:0] t);
    begin
      i_pres_sample <= p;
      i_temp_sample <= t;
      i_sample_valid <= 1'b1;
      @(posedge i_sys_clk);
      i_sample_valid <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    rows[0] = 56'h06_ee_00_01_20_00_40;
    rows[1] = 56'h01_12_35_70_ac_00_00;
    rows[2] = 56'h07_00_01_20_00_40_00;
    rows[3] = 56'h0f_00_21_01_42_05_12;
    rows[4] = 56'h0c_5a_3c_77_77_77_77;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk("ref", o_sea_level_ref, 16'hc5e7);
    pt(8'h14);
    alt_i2c_host_i.xfer(8'h12, 1'b1, q, ak);
    alt_i2c_host_i.xfer(8'h34, 1'b1, q, ak);
    alt_i2c_host_i.stop;
    chk("ref", o_sea_level_ref, 16'h1234);
    i_active <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk("ref", o_sea_level_ref, 16'h1234);
    wr(8'h13, 8'h05);
    chk("event cfg", o_data_event_config, 8'h05);
    smp(20'h12345, 12'habc);
    smp(20'h12357, 12'hac0);
    p0 = pops;
    for (r = 0; r < 5; r = r + 1)
      rd_chk(rows[r][55:48], rows[r][47:0]);
    chk("pops", pops - p0, 4);
    wr(8'h0f, 8'h40);
    chk("fifo cfg", o_fifo_config, 8'h40);
    rd_chk(8'h00, 48'h3c_77_77_77_77_77);
    wr(8'h0f, 8'h00);
    // fresh sample so the clear below has something to wipe
    smp(20'h0abcd, 12'h123);
    i_active <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_active <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    rd_chk(8'h01, 48'h0);
    alt_i2c_host_i.start;
    alt_i2c_host_i.xfer({7'h61, 1'b0}, 1'b1, q, ak);
    chk("foreign addr nack", ak, 1);
    alt_i2c_host_i.stop;
    i_rst_n <= 1'b0;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk("fifo cfg", o_fifo_config, 8'h00);
    rd_chk(8'h10, 48'h21_01_42_00_c5_e7);
    print_verdict;
  end
  initial
  begin
    repeat (60000) @(posedge i_sys_clk);
    err_count = err_count + 1;
    print_verdict;
  end
endmodule // alt_reg_map_tb
